// File: verilog/lstc_pkg.sv
package lstc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACCESS = 2'b01,
    ST_DONE   = 2'b11
  } lstc_apb_e;

  // Command qualifiers
  localparam logic [1:0]  RS_MAIN      = 2'b00;
  localparam logic [1:0]  RS_TEMP      = 2'b10;
  localparam logic [7:0]  OP_CLR_FLAG  = 8'h1F;
  localparam logic [3:0]  OP_PUMP      = 4'hC;
  localparam logic [2:0]  OP_VMSB      = 3'b010;
  localparam logic [3:0]  OP_VLSB      = 4'h6;
  localparam logic [5:0]  OP_BIAS      = 6'b110100;
  localparam logic [4:0]  OP_TCTRL     = 5'b00000;
  localparam int          THR_NUM      = 4;
  localparam int          INTERVAL_NUM = 6;
  localparam logic [19:0] OP_THR       = {5'b01010, 5'b01001, 5'b01000, 5'b00111};

  // Field positions
  localparam int PUMP_EN_BIT   = 3;
  localparam int DIRECT_BIT    = 2;
  localparam int TC_COMP_BIT   = 2;
  localparam int TC_FILT_BIT   = 1;
  localparam int TC_MEAS_BIT   = 0;
  localparam int STAT_PUMP_BIT = 6;
  localparam int STAT_FLAG_BIT = 4;
  localparam int CMD_RW_BIT    = 10;
  localparam int CMD_RS_LSB    = 8;

  // Reset values and bias codes
  localparam logic       FLAG_RST    = 1'b1;
  localparam logic       PUMP_EN_RST = 1'b0;
  localparam logic [2:0] MULT_RST    = 3'h0;
  localparam logic [4:0] VHI_RST     = 5'h00;
  localparam logic [3:0] VLO_RST     = 4'h0;
  localparam logic [1:0] BIAS_THIRD  = 2'b11;
  localparam logic [1:0] BIAS_HALF   = 2'b10;
  localparam logic [1:0] BIAS_RST    = BIAS_THIRD;
  localparam logic [2:0] TCTRL_RST   = 3'h0;
  localparam logic [2:0] THR_RST     = 3'h0;

  // Supply voltage scale in millivolts, code limit and pump factors
  localparam logic [13:0] VMIN_MV   = 14'h0FA0;
  localparam logic [13:0] VMAX_MV   = 14'h2EE0;
  localparam logic [13:0] VSTEP_MV  = 14'h001E;
  localparam logic [8:0]  VCODE_TOP = 9'h10C;
  localparam logic [2:0]  MULT_BASE = 3'h2;
  localparam logic [2:0]  MULT_ONE  = 3'h1;

  // Register map
  localparam int         ADDR_W   = 8;
  localparam logic [7:0] OFF_CMD  = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_SUPP = 8'h08;
  localparam logic [7:0] OFF_VOLT = 8'h0C;
  localparam logic [7:0] OFF_TCTL = 8'h10;
  localparam logic [7:0] OFF_THR  = 8'h14;
  localparam logic [7:0] OFF_TEMP = 8'h18;

endpackage

// File: verilog/lstc_core_if.sv
`timescale 1ns/100ps
interface lstc_core_if;
  logic       cmdValid;
  logic       cmdRw;
  logic [1:0] cmdRs;
  logic [7:0] cmdByte;
  logic       measureEn;
  logic       filterEn;
  logic [7:0] rawTemp;
  logic       rawValid;
  logic [7:0] tempResult;
  logic       tempValid;

  modport link (output cmdValid, cmdRw, cmdRs, cmdByte);
  modport temp (input measureEn, filterEn, rawTemp, rawValid, output tempResult, tempValid);
  modport core (input cmdValid, cmdRw, cmdRs, cmdByte, tempResult, tempValid,
                output measureEn, filterEn, rawTemp, rawValid);
endinterface

// File: verilog/lstc_link_rx.sv
`timescale 1ns/100ps
module lstc_link_rx (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       linkClk,
  input  wire logic       linkRw,
  input  wire logic [1:0] linkRs,
  input  wire logic [7:0] linkByte,
  lstc_core_if.link       bus
);
  import lstc_pkg::*;

  logic [11:0] pinIn;
  logic [11:0] meta_r;
  logic [11:0] sync_r;
  logic        clkDly_r;
  logic        rise;

  assign pinIn = {linkClk, linkRw, linkRs, linkByte};

  // Two-stage synchroniser per pin
  genvar i;
  generate
    for (i = 0; i < 12; i++) begin : g_sync
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          meta_r[i] <= 1'b0;
          sync_r[i] <= 1'b0;
        end else begin
          meta_r[i] <= pinIn[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clkDly_r <= 1'b0;
    end else begin
      clkDly_r <= sync_r[11];
    end
  end

  assign rise = sync_r[11] & ~clkDly_r;

  // One command per rising link clock edge
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bus.cmdValid <= 1'b0;
      bus.cmdRw    <= 1'b0;
      bus.cmdRs    <= RS_MAIN;
      bus.cmdByte  <= 8'h00;
    end else begin
      bus.cmdValid <= rise;
      if (rise) begin
        bus.cmdRw   <= sync_r[10];
        bus.cmdRs   <= sync_r[9:8];
        bus.cmdByte <= sync_r[7:0];
      end
    end
  end
endmodule

// File: verilog/lstc_temp_path.sv
`timescale 1ns/100ps
module lstc_temp_path (
  input  wire logic ref_clk,
  input  wire logic rstn,
  lstc_core_if.temp bus
);
  import lstc_pkg::*;

  logic [8:0] avgSum;

  assign avgSum = {1'b0, bus.tempResult} + {1'b0, bus.rawTemp};

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bus.tempResult <= 8'h00;
      bus.tempValid  <= 1'b0;
    end else if (!bus.measureEn) begin
      bus.tempResult <= 8'h00;
      bus.tempValid  <= 1'b0;
    end else if (bus.rawValid) begin
      bus.tempValid <= 1'b1;
      if (!bus.filterEn || !bus.tempValid) begin
        bus.tempResult <= bus.rawTemp;
      end else begin
        bus.tempResult <= avgSum[8:1];
      end
    end
  end
endmodule

// File: verilog/lstc_cmd_decoder.sv
// Operation
// - Clear-flag command clears reset seen flag
// - Pump command bit 3 enables pump
// - Pump bits 2-0 choose multiplier or direct
// - MSB command loads voltage code bits 8-4
// - LSB command loads voltage code bits 3-0
// - Code zero 4 V, 10Ch up 12 V
// - Each code step adds 0.03 V
// - Bias command selects third or half bias
// - Temperature control sets compensation, filter, measurement
// - Measurement off gives no valid temperature
// - Filter off passes raw result at once
// - Six temperature intervals over operating range
// - Threshold commands store interval thresholds one-four
// - Any reset source sets reset seen flag
// - Status bit 6 mirrors pump enable
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/100ps
module lstc_cmd_decoder (
  input  wire logic                     ref_clk,
  input  wire logic                     rstn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [lstc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     linkClk,
  input  wire logic                     linkRw,
  input  wire logic [1:0]               linkRs,
  input  wire logic [7:0]               linkByte,
  input  wire logic                     initReq,
  input  wire logic [7:0]               rawTemp,
  input  wire logic                     rawTempValid,
  output logic                          resetSeenFlag,
  output logic [7:0]                    statusByte,
  output logic                          pumpEnable,
  output logic [2:0]                    pumpMultiplierSel,
  output logic [2:0]                    pumpFactor,
  output logic [8:0]                    vlcdCode,
  output logic [13:0]                   vlcdMv,
  output logic [1:0]                    biasMode,
  output logic                          voltCompEnable,
  output logic                          tempFilterEnable,
  output logic                          tempMeasureEnable,
  output logic [7:0]                    tempResult,
  output logic                          tempValid,
  output logic [2:0]                    intervalThreshold1,
  output logic [2:0]                    intervalThreshold2,
  output logic [2:0]                    intervalThreshold3,
  output logic [2:0]                    intervalThreshold4
);
  import lstc_pkg::*;

  lstc_core_if core ();

  lstc_apb_e  apbState_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [10:0] apbCmd_r;
  logic        apbPend_r;

  logic        selValid;
  logic        selRw;
  logic [1:0]  selRs;
  logic [7:0]  selByte;
  logic        fromLink;

  logic        flag_r;
  logic        flag_nxt;
  logic        flagClr;
  logic        pumpEn_r;
  logic        pumpEn_nxt;
  logic [2:0]  mult_r;
  logic [2:0]  mult_nxt;
  logic [4:0]  vHi_r;
  logic [4:0]  vHi_nxt;
  logic [3:0]  vLo_r;
  logic [3:0]  vLo_nxt;
  logic [1:0]  bias_r;
  logic [1:0]  bias_nxt;
  logic [2:0]  tctl_r;
  logic [2:0]  tctl_nxt;
  logic [THR_NUM-1:0] thrHit;
  logic [2:0]  thr_r [THR_NUM];
  logic        known;
  logic [7:0]  ignoredCnt_r;

  logic [2:0]  factor_r;
  logic [13:0] mv_r;
  logic [7:0]  status_r;
  logic [8:0]  codeNxt;
  logic [13:0] mvLin;
  logic [31:0] readMux;
  logic        addrOk;

  lstc_link_rx u_link (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .linkClk  (linkClk),
    .linkRw   (linkRw),
    .linkRs   (linkRs),
    .linkByte (linkByte),
    .bus      (core.link)
  );

  lstc_temp_path u_temp (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .bus     (core.temp)
  );

  assign core.measureEn = tctl_r[TC_MEAS_BIT];
  assign core.filterEn  = tctl_r[TC_FILT_BIT];
  assign core.rawTemp   = rawTemp;
  assign core.rawValid  = rawTempValid;

  // APB slave: setup, access, then one cycle with pready high
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      apbState_r <= ST_IDLE;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      prdata_r   <= 32'h0000_0000;
    end else begin
      case (apbState_r)
        ST_IDLE: begin
          pready_r  <= 1'b0;
          pslverr_r <= 1'b0;
          if (psel && !penable) begin
            apbState_r <= ST_ACCESS;
          end
        end
        ST_ACCESS: begin
          if (psel && penable) begin
            apbState_r <= ST_DONE;
            pready_r   <= 1'b1;
            pslverr_r  <= !addrOk;
            prdata_r   <= (!pwrite && addrOk) ? readMux : 32'h0000_0000;
          end else begin
            apbState_r <= ST_IDLE;
          end
        end
        ST_DONE: begin
          apbState_r <= ST_IDLE;
          pready_r   <= 1'b0;
          pslverr_r  <= 1'b0;
        end
        default: begin
          apbState_r <= ST_IDLE;
          pready_r   <= 1'b0;
          pslverr_r  <= 1'b0;
        end
      endcase
    end
  end

  // Command register write queues one command for the decoder
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      apbCmd_r  <= 11'h000;
      apbPend_r <= 1'b0;
    end else begin
      if (apbState_r == ST_DONE && pwrite && paddr == OFF_CMD) begin
        apbCmd_r  <= pwdata[10:0];
        apbPend_r <= 1'b1;
      end else if (!core.cmdValid) begin
        apbPend_r <= 1'b0;
      end
    end
  end

  // Address decode
  always_comb begin
    addrOk  = 1'b1;
    readMux = 32'h0000_0000;
    if (paddr == OFF_CMD) begin
      readMux = {21'h00_0000, apbCmd_r};
    end else if (paddr == OFF_STAT) begin
      readMux = {16'h0000, ignoredCnt_r, status_r};
    end else if (paddr == OFF_SUPP) begin
      readMux = {23'h00_0000, bias_r, factor_r, pumpEn_r, mult_r};
    end else if (paddr == OFF_VOLT) begin
      readMux = {2'b00, mv_r, 7'h00, vHi_r, vLo_r};
    end else if (paddr == OFF_TCTL) begin
      readMux = {29'h0000_0000, tctl_r};
    end else if (paddr == OFF_THR) begin
      readMux = {17'h0_0000, thr_r[3], 1'b0, thr_r[2], 1'b0, thr_r[1], 1'b0, thr_r[0]};
    end else if (paddr == OFF_TEMP) begin
      readMux = {23'h00_0000, core.tempValid, core.tempResult};
    end else begin
      addrOk = 1'b0;
    end
  end

  // Link command wins; a queued register command waits one cycle
  assign fromLink = core.cmdValid;
  assign selValid = core.cmdValid || apbPend_r;
  assign selRw    = fromLink ? core.cmdRw   : apbCmd_r[CMD_RW_BIT];
  assign selRs    = fromLink ? core.cmdRs   : apbCmd_r[CMD_RS_LSB+1:CMD_RS_LSB];
  assign selByte  = fromLink ? core.cmdByte : apbCmd_r[7:0];

  // Command decode
  always_comb begin
    flagClr    = 1'b0;
    pumpEn_nxt = pumpEn_r;
    mult_nxt   = mult_r;
    vHi_nxt    = vHi_r;
    vLo_nxt    = vLo_r;
    bias_nxt   = bias_r;
    tctl_nxt   = tctl_r;
    thrHit     = '0;
    known      = 1'b0;
    if (selValid && !selRw) begin
      if (selRs == RS_MAIN) begin
        if (selByte == OP_CLR_FLAG) begin
          flagClr = 1'b1;
          known   = 1'b1;
        end else if (selByte[7:4] == OP_PUMP) begin
          pumpEn_nxt = selByte[PUMP_EN_BIT];
          mult_nxt   = selByte[2:0];
          known      = 1'b1;
        end else if (selByte[7:5] == OP_VMSB) begin
          vHi_nxt = selByte[4:0];
          known   = 1'b1;
        end else if (selByte[7:4] == OP_VLSB) begin
          vLo_nxt = selByte[3:0];
          known   = 1'b1;
        end else if (selByte[7:2] == OP_BIAS && selByte[1]) begin
          bias_nxt = selByte[1:0];
          known    = 1'b1;
        end
      end else if (selRs == RS_TEMP) begin
        if (selByte[7:3] == OP_TCTRL) begin
          tctl_nxt = selByte[2:0];
          known    = 1'b1;
        end
        for (int k = 0; k < THR_NUM; k++) begin
          if (selByte[7:3] == OP_THR[k*5 +: 5]) begin
            thrHit[k] = 1'b1;
            known     = 1'b1;
          end
        end
      end
    end
  end

  // Reset or initialize sets the flag and beats a clear
  assign flag_nxt = initReq ? 1'b1 : (flagClr ? 1'b0 : flag_r);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flag_r <= FLAG_RST;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pumpEn_r <= PUMP_EN_RST;
      mult_r   <= MULT_RST;
      bias_r   <= BIAS_RST;
    end else begin
      pumpEn_r <= pumpEn_nxt;
      mult_r   <= mult_nxt;
      bias_r   <= bias_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      vHi_r <= VHI_RST;
      vLo_r <= VLO_RST;
    end else begin
      vHi_r <= vHi_nxt;
      vLo_r <= vLo_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tctl_r <= TCTRL_RST;
    end else begin
      tctl_r <= tctl_nxt;
    end
  end

  // Interval thresholds one to four; the upper two intervals lie beyond threshold four
  genvar t;
  generate
    for (t = 0; t < THR_NUM; t++) begin : g_thr
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          thr_r[t] <= THR_RST;
        end else if (thrHit[t]) begin
          thr_r[t] <= selByte[2:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ignoredCnt_r <= 8'h00;
    end else if (selValid && !known && ignoredCnt_r != 8'hFF) begin
      ignoredCnt_r <= ignoredCnt_r + 8'h01;
    end
  end

  // Derived supply settings, registered from next values
  assign codeNxt = {vHi_nxt, vLo_nxt};
  assign mvLin   = 14'(VMIN_MV + 14'(codeNxt) * VSTEP_MV);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      factor_r <= MULT_BASE;
      mv_r     <= VMIN_MV;
      status_r <= 8'h00;
    end else begin
      factor_r <= mult_nxt[DIRECT_BIT] ? MULT_ONE : 3'(mult_nxt + MULT_BASE);
      mv_r     <= (codeNxt >= VCODE_TOP) ? VMAX_MV : mvLin;
      status_r <= 8'h00;
      status_r[STAT_PUMP_BIT] <= pumpEn_nxt;
      status_r[STAT_FLAG_BIT] <= flag_nxt;
    end
  end

  assign prdata             = prdata_r;
  assign pready             = pready_r;
  assign pslverr            = pslverr_r;
  assign resetSeenFlag      = flag_r;
  assign statusByte         = status_r;
  assign pumpEnable         = pumpEn_r;
  assign pumpMultiplierSel  = mult_r;
  assign pumpFactor         = factor_r;
  assign vlcdCode           = {vHi_r, vLo_r};
  assign vlcdMv             = mv_r;
  assign biasMode           = bias_r;
  assign voltCompEnable     = tctl_r[TC_COMP_BIT];
  assign tempFilterEnable   = tctl_r[TC_FILT_BIT];
  assign tempMeasureEnable  = tctl_r[TC_MEAS_BIT];
  assign tempResult         = core.tempResult;
  assign tempValid          = core.tempValid;
  assign intervalThreshold1 = thr_r[0];
  assign intervalThreshold2 = thr_r[1];
  assign intervalThreshold3 = thr_r[2];
  assign intervalThreshold4 = thr_r[3];
endmodule

// File: verification/lstc_cmd_decoder_asserts.sv
`timescale 1ns/100ps
module lstc_cmd_decoder_asserts (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        initReq,
  input wire logic [7:0]  rawTemp,
  input wire logic        rawTempValid,
  input wire logic        resetSeenFlag,
  input wire logic [7:0]  statusByte,
  input wire logic        pumpEnable,
  input wire logic [2:0]  pumpMultiplierSel,
  input wire logic [2:0]  pumpFactor,
  input wire logic [8:0]  vlcdCode,
  input wire logic [13:0] vlcdMv,
  input wire logic [1:0]  biasMode,
  input wire logic        tempFilterEnable,
  input wire logic        tempMeasureEnable,
  input wire logic [7:0]  tempResult,
  input wire logic        tempValid
);
  import lstc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [13:0] mvExp;
  logic [2:0]  facExp;
  assign mvExp  = (vlcdCode >= VCODE_TOP) ? VMAX_MV : VMIN_MV + 14'(vlcdCode) * VSTEP_MV;
  assign facExp = pumpMultiplierSel[DIRECT_BIT] ? MULT_ONE : pumpMultiplierSel + MULT_BASE;
  a_flag_on_init: assert property (
    initReq |-> ##[1:2] resetSeenFlag) else $error("reset flag not set by init");
  a_stat_flag: assert property (
    rstn && $past(rstn) |-> statusByte[STAT_FLAG_BIT] == resetSeenFlag)
    else $error("status bit 4 differs from reset flag");
  a_stat_pump: assert property (
    $stable(pumpEnable) [*2] |-> statusByte[STAT_PUMP_BIT] == pumpEnable)
    else $error("status bit 6 differs from pump enable");
  a_factor_map: assert property (
    $stable(pumpMultiplierSel) [*2] |-> pumpFactor == facExp)
    else $error("pump factor wrong for multiplier code");
  a_mv_map: assert property (
    $stable(vlcdCode) [*2] |-> vlcdMv == mvExp) else $error("voltage wrong for code");
  a_code_halves: assert property (
    $changed(vlcdCode[8:4]) |-> $stable(vlcdCode[3:0]))
    else $error("high half write disturbed low half");
  a_bias_legal: assert property (
    biasMode == BIAS_THIRD || biasMode == BIAS_HALF) else $error("bias mode unused code");
  a_temp_off: assert property (
    !tempMeasureEnable [*2] |-> !tempValid && tempResult == 8'h00)
    else $error("temperature offered while measurement off");
  a_temp_raw: assert property (
    tempMeasureEnable && !tempFilterEnable && rawTempValid
      |=> tempValid && tempResult == $past(rawTemp)) else $error("raw sample not passed");
endmodule

bind lstc_cmd_decoder lstc_cmd_decoder_asserts u_lstc_cmd_decoder_asserts (.*);

// File: verification/lstc_host_model.sv
`timescale 1ns/100ps
module lstc_host_model (
  output logic       linkClk,
  output logic       linkRw,
  output logic [1:0] linkRs,
  output logic [7:0] linkByte
);
  logic frameClk;
  initial begin
    frameClk = 1'b0;
    linkClk  = 1'b0;
    linkRw   = 1'b1;
    linkRs   = 2'b11;
    linkByte = 8'hA5;
  end
  // Bit timing runs free, linkClk only pulses inside a command frame
  initial begin
    #3.3;
    forever #24 frameClk = ~frameClk;
  end
  task automatic send(input logic rw, input logic [1:0] rs, input logic [7:0] b);
    @(negedge frameClk);
    linkRw   <= rw;
    linkRs   <= rs;
    linkByte <= b;
    @(posedge frameClk);
    linkClk  <= 1'b1;
    @(negedge frameClk);
    linkClk  <= 1'b0;
    @(posedge frameClk);
    // Released lines show the inverse so stale data cannot pass
    linkRw   <= ~rw;
    linkRs   <= ~rs;
    linkByte <= ~b;
  endtask
endmodule

// File: verification/tb.sv
`timescale 1ns/100ps
module tb;
  import lstc_pkg::*;
  logic        ref_clk, rstn, psel, penable, pwrite, pready, pslverr, er;
  logic        linkClk, linkRw, initReq, rawTempValid, resetSeenFlag, pumpEnable;
  logic        voltCompEnable, tempFilterEnable, tempMeasureEnable, tempValid;
  logic [1:0]  linkRs, biasMode;
  logic [2:0]  pumpMultiplierSel, pumpFactor;
  logic [2:0]  intervalThreshold1, intervalThreshold2, intervalThreshold3, intervalThreshold4;
  logic [7:0]  paddr, linkByte, rawTemp, statusByte, tempResult;
  logic [8:0]  vlcdCode;
  logic [13:0] vlcdMv;
  logic [31:0] pwdata, prdata, rd;
  int          n_mismatch, tests_run;

  lstc_cmd_decoder u_lstc_cmd_decoder (.*);
  lstc_host_model  u_lstc_host_model (.*);

  always #2.5 ref_clk = ~ref_clk;

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, rd, e);
  endtask

  task automatic wcmd(input logic [1:0] rs, input logic [7:0] b);
    apb(1'b1, OFF_CMD, 32'({1'b0, rs, b}));
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic lk(input logic [1:0] rs, input logic [7:0] b);
    u_lstc_host_model.send(1'b0, rs, b);
  endtask

  task automatic raw(input logic [7:0] v);
    @(posedge ref_clk);
    rawTemp      <= v;
    rawTempValid <= 1'b1;
    @(posedge ref_clk);
    rawTempValid <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  initial begin
    ref_clk      = 1'b0;
    rstn         = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 8'h00;
    pwdata       = 32'h0000_0000;
    initReq      = 1'b0;
    rawTemp      = 8'h00;
    rawTempValid = 1'b0;
    n_mismatch   = 0;
    tests_run    = 0;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    chk("flag", resetSeenFlag, 1);
    rchk(OFF_STAT, 32'h0000_0010, "stat");
    rchk(OFF_SUPP, 32'h0000_01A0, "supp");
    chk("mvReset", vlcdMv, VMIN_MV);
    lk(RS_MAIN, OP_CLR_FLAG);
    chk("flagClr", resetSeenFlag, 0);
    @(posedge ref_clk);
    initReq <= 1'b1;
    @(posedge ref_clk);
    initReq <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("flagInit", resetSeenFlag, 1);
    wcmd(RS_MAIN, OP_CLR_FLAG);
    chk("flagApb", resetSeenFlag, 0);
    rstn <= 1'b0;
    @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("flagPin", resetSeenFlag, 1);
    for (int i = 0; i < 16; i++) begin
      lk(RS_MAIN, {OP_PUMP, 4'(i)});
      chk("pumpEn", pumpEnable, i[3]);
      chk("stat6", statusByte[STAT_PUMP_BIT], i[3]);
      chk("mult", pumpMultiplierSel, i[2:0]);
      chk("factor", pumpFactor, i[2] ? 1 : i[1:0] + 2);
    end
    lk(RS_MAIN, {OP_VMSB, 5'h10});
    lk(RS_MAIN, {OP_VLSB, 4'hC});
    chk("code", vlcdCode, 9'h10C);
    chk("mvTop", vlcdMv, VMAX_MV);
    lk(RS_MAIN, {OP_VLSB, 4'hB});
    chk("mvStep", vlcdMv, VMIN_MV + VSTEP_MV * 9'h10B);
    lk(RS_MAIN, {OP_VMSB, 5'h00});
    chk("codeHalf", vlcdCode, 9'h00B);
    chk("mvLow", vlcdMv, VMIN_MV + VSTEP_MV * 9'h00B);
    for (int i = 3; i >= 0; i--) begin
      lk(RS_MAIN, {OP_BIAS, 2'(i)});
      chk("bias", biasMode, i > 1 ? i : 2);
    end
    for (int i = 0; i < 8; i++) begin
      lk(RS_TEMP, {OP_TCTRL, 3'(i)});
      chk("tctl", {voltCompEnable, tempFilterEnable, tempMeasureEnable}, i);
    end
    lk(RS_TEMP, {OP_TCTRL, 3'b001});
    raw(8'h5A);
    chk("temp", {tempValid, tempResult}, 9'h15A);
    raw(8'h3C);
    rchk(OFF_TEMP, 32'h0000_013C, "tempReg");
    lk(RS_TEMP, {OP_TCTRL, 3'b000});
    raw(8'h77);
    chk("tempOff", {tempValid, tempResult}, 0);
    for (int i = 0; i < THR_NUM; i++) begin
      lk(RS_TEMP, {OP_THR[i*5 +: 5], 3'(7 - i)});
    end
    rchk(OFF_THR, 32'h0000_4567, "thrReg");
    lk(RS_MAIN, {OP_PUMP, 4'hA});
    u_lstc_host_model.send(1'b1, RS_MAIN, 8'hC5);
    lk(2'b01, 8'hC5);
    lk(2'b11, 8'hC5);
    lk(RS_TEMP, 8'hC5);
    apb(1'b1, OFF_TCTL, 32'h0000_0007);
    repeat (3) @(posedge ref_clk);
    chk("keep", {pumpEnable, pumpMultiplierSel, intervalThreshold4, intervalThreshold3,
                 intervalThreshold2, intervalThreshold1, tempMeasureEnable}, 17'h1_52EE);
    rchk(OFF_STAT, 32'h0000_0650, "ignored");
    rchk(8'h40, 32'h0000_0000, "unmapped");
    chk("slverr", er, 1);
    end_sim();
  end
endmodule
